// *** wmi_consts.vh ***
// constants for the wake and management interrupt aggregator
`ifndef WMI_CONSTS_VH
`define WMI_CONSTS_VH

// ----------------------------------------
// register indexes, byte address is four times
// ----------------------------------------
`define WMI_IDX_WAKE_STS_A  5'h02
`define WMI_IDX_WAKE_STS_B  5'h03
`define WMI_IDX_WAKE_STS_P  5'h04
`define WMI_IDX_WAKE_EN_A   5'h05
`define WMI_IDX_WAKE_EN_B   5'h06
`define WMI_IDX_WAKE_EN_P   5'h07
`define WMI_IDX_SUMMARY     5'h10
`define WMI_IDX_MASTER_EN   5'h11
`define WMI_IDX_SRC_STS_A   5'h12
`define WMI_IDX_SRC_STS_B   5'h13
`define WMI_IDX_SRC_EN_A    5'h15
`define WMI_IDX_SRC_EN_B    5'h16
`define WMI_IDX_WAKE_GATE   5'h18

// ----------------------------------------
// field masks and positions
// ----------------------------------------
`define WMI_WAKE_A_MASK     8'h3E
`define WMI_WAKE_B_MASK     8'h7F
`define WMI_WAKE_B_STICKY   8'h23
`define WMI_SRC_EN_B_MASK   8'hFB
`define WMI_SRC_B_SOURCES   8'h1B
`define WMI_BIT0            0
`define WMI_WSB_DEVINT      0
`define WMI_WSB_WDT         1
`define WMI_WSB_MB1         2
`define WMI_WSB_MB2         3
`define WMI_WSB_FW          4
`define WMI_WSB_LOWBAT      5
`define WMI_WSB_INTR        6
`define WMI_PIN_H           7
`define WMI_ROUTE_PIN       7
`define WMI_ROUTE_SIRQ      6
`define WMI_ROUTE_WAKE      5
`define WMI_SRCB_WDT        3
`define WMI_SRCB_RSVD       2
`define WMI_ZERO8           8'h00
`define WMI_ZERO32          32'h0000_0000
`define WMI_ADR_MSB         7
`define WMI_IDX_MSB         6
`define WMI_IDX_LSB         2

`endif

// *** wmi_wake_mgmt_irq.v ***
// wake and management interrupt aggregator with a classic wishbone slave
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "wmi_consts.vh"

module wmi_wake_mgmt_irq #(
  parameter MBX_W = 16,
  parameter FW_W  = 8
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire [7:0]       wbAdrI,
  input  wire [31:0]      wbDatI,
  input  wire [3:0]       wbSelI,
  input  wire             wbWeI,
  input  wire             wbCycI,
  input  wire             wbStbI,
  output reg  [31:0]      wbDatO,
  output reg              wbAckO,
  input  wire [5:1]       wakeEvtA,
  input  wire [7:0]       pinWakeEvt,
  input  wire             watchdogEvt,
  input  wire             intrusionIn,
  input  wire             mainRstN,
  input  wire             vbatPorIn,
  input  wire             vbatLowIn,
  input  wire             parportActive,
  input  wire             parportAck,
  input  wire             serialBIrq,
  input  wire             serialAIrq,
  input  wire             floppyIrq,
  input  wire [MBX_W-1:0] mbxSrc,
  input  wire [MBX_W-1:0] mbxEn,
  input  wire [FW_W-1:0]  fwEvtSts,
  input  wire [FW_W-1:0]  fwEvtEn,
  input  wire             keyboardIrq,
  input  wire             mouseIrq,
  output reg              mgmtIntOutN,
  output reg              serialIrqMgmt,
  output reg              wakeOutN
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // sticky flag update: a set in the same cycle as a clear wins
  function [7:0] w1cNext;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      w1cNext = set | (cur & ~clr);
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [7:0] wakeStsA;
  reg  [7:0] wakeStsB;
  reg  [7:0] wakeStsPins;
  reg  [7:0] wakeEnA;
  reg  [7:0] wakeEnB;
  reg  [7:0] wakeEnPins;
  reg  [7:0] srcEnA;
  reg  [7:0] srcEnB;
  reg        sumFlag;
  reg        masterEn;
  reg        lowBat;
  reg        wdtFlag;
  reg        wakeGate;
  reg        porDone;
  reg        mainRstQ;
  reg  [7:0] rdData;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire       wbReq   = wbCycI & wbStbI;
  // writes land on the edge that the master samples ack
  wire       wrEn    = wbReq & wbWeI & wbAckO & wbSelI[0];
  wire [4:0] idx     = wbAdrI[`WMI_IDX_MSB:`WMI_IDX_LSB];
  wire       inRange = ~wbAdrI[`WMI_ADR_MSB];
  wire [7:0] wd      = wbDatI[7:0];

  function hit;
    input [4:0] i;
    begin
      hit = wrEn & inRange & (idx == i);
    end
  endfunction

  wire [7:0] clrWakeA = hit(`WMI_IDX_WAKE_STS_A) ? wd : `WMI_ZERO8;
  wire [7:0] clrWakeB = hit(`WMI_IDX_WAKE_STS_B) ? wd : `WMI_ZERO8;
  wire [7:0] clrWakeP = hit(`WMI_IDX_WAKE_STS_P) ? wd : `WMI_ZERO8;
  wire [7:0] clrSrcA  = hit(`WMI_IDX_SRC_STS_A) ? wd : `WMI_ZERO8;
  wire [7:0] clrSrcB  = hit(`WMI_IDX_SRC_STS_B) ? wd : `WMI_ZERO8;
  wire       clrSum   = hit(`WMI_IDX_SUMMARY) & wd[`WMI_BIT0];

  // ----------------------------------------
  // write strobes
  // ----------------------------------------
  // decoded once so every register sees a single strobe
  // a write with sel[0] low or to an unmapped index raises none
  wire       wrWakeEnA  = hit(`WMI_IDX_WAKE_EN_A);
  wire       wrWakeEnB  = hit(`WMI_IDX_WAKE_EN_B);
  wire       wrWakeEnP  = hit(`WMI_IDX_WAKE_EN_P);
  wire       wrSrcEnA   = hit(`WMI_IDX_SRC_EN_A);
  wire       wrSrcEnB   = hit(`WMI_IDX_SRC_EN_B);
  wire       wrMasterEn = hit(`WMI_IDX_MASTER_EN);
  wire       wrWakeGate = hit(`WMI_IDX_WAKE_GATE);

  // ----------------------------------------
  // source status a
  // ----------------------------------------
  wire fwFlag   = |(fwEvtSts & fwEvtEn);
  wire mbxAny   = |(mbxSrc & mbxEn);
  wire mbxWrote = mbxSrc[0];
  wire parFlag  = parportActive ? parportAck : 1'b1;

  wire [7:0] srcStsA = {
    fwFlag,
    mbxAny,
    mbxWrote,
    floppyIrq,
    serialAIrq,
    serialBIrq,
    parFlag,
    lowBat
  };

  // ----------------------------------------
  // source status b
  // ----------------------------------------
  // reserved bit 2 reads one and is kept out of the sources
  wire [7:0] srcStsB = {
    4'h0,
    wdtFlag,
    1'b1,
    keyboardIrq,
    mouseIrq
  };

  // ----------------------------------------
  // management interrupt summary
  // ----------------------------------------
  wire anySrcA = |(srcStsA & srcEnA);
  wire anySrcB = |(srcStsB & srcEnB & `WMI_SRC_B_SOURCES);
  wire anySrc  = anySrcA | anySrcB;
  wire mgmtActive = sumFlag & masterEn;

  // ----------------------------------------
  // wake status b view
  // ----------------------------------------
  // intrusion and the event flags are live copies; only the
  // sticky bits are stored
  wire [7:0] wakeStsBView = (wakeStsB & `WMI_WAKE_B_STICKY) | {
    1'b0,
    intrusionIn,
    1'b0,
    fwFlag,
    mbxAny,
    mbxWrote,
    2'b00
  };

  wire       mainRelease = mainRstN & ~mainRstQ;
  wire [7:0] wakeSetB;
  assign wakeSetB[`WMI_WSB_DEVINT] = mgmtActive & srcEnB[`WMI_ROUTE_WAKE];
  assign wakeSetB[`WMI_WSB_WDT]    = watchdogEvt;
  assign wakeSetB[`WMI_WSB_MB1]    = 1'b0;
  assign wakeSetB[`WMI_WSB_MB2]    = 1'b0;
  assign wakeSetB[`WMI_WSB_FW]     = 1'b0;
  assign wakeSetB[`WMI_WSB_LOWBAT] = mainRelease & vbatLowIn;
  assign wakeSetB[7:6]             = 2'b00;

  wire wakeSummary = (|(wakeStsA & wakeEnA)) |
                     (|(wakeStsBView & wakeEnB)) |
                     (|(wakeStsPins & wakeEnPins));

  // ----------------------------------------
  // supply sequencing
  // ----------------------------------------
  // mainRstQ resets low: a main supply already up counts as released at the
  // first edge, where lowBat takes the power-on load instead

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      porDone  <= 1'b0;
      mainRstQ <= 1'b0;
    end else begin
      porDone  <= 1'b1;
      mainRstQ <= mainRstN;
    end
  end

  // first cycle after standby reset loads, later only sets or clears
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lowBat <= 1'b0;
    end else if (!porDone) begin
      lowBat <= vbatPorIn;
    end else begin
      lowBat <= (mainRelease & vbatLowIn) |
                (lowBat & ~clrSrcA[`WMI_BIT0]);
    end
  end

  // ----------------------------------------
  // sticky wake and watchdog flags
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gPin
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          wakeStsPins[g] <= 1'b0;
        end else begin
          wakeStsPins[g] <= pinWakeEvt[g] | (wakeStsPins[g] & ~clrWakeP[g]);
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wakeStsA <= `WMI_ZERO8;
    end else begin
      wakeStsA <= w1cNext(wakeStsA, {2'b00, wakeEvtA, 1'b0}, clrWakeA) &
                  `WMI_WAKE_A_MASK;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wakeStsB <= `WMI_ZERO8;
    end else begin
      wakeStsB <= w1cNext(wakeStsB, wakeSetB, clrWakeB) & `WMI_WAKE_B_STICKY;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdtFlag <= 1'b0;
    end else begin
      wdtFlag <= watchdogEvt | (wdtFlag & ~clrSrcB[`WMI_SRCB_WDT]);
    end
  end

  // ----------------------------------------
  // summary status
  // ----------------------------------------
  // an enabled source still high sets the flag again at the same edge as the clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sumFlag <= 1'b0;
    end else begin
      sumFlag <= anySrc | (sumFlag & ~clrSum);
    end
  end

  // ----------------------------------------
  // software writable registers
  // ----------------------------------------
  // standby power-on reset is the only reset here, so it clears every enable
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wakeEnA    <= `WMI_ZERO8;
      wakeEnB    <= `WMI_ZERO8;
      wakeEnPins <= `WMI_ZERO8;
    end else begin
      if (wrWakeEnA) begin
        wakeEnA <= wd & `WMI_WAKE_A_MASK;
      end
      if (wrWakeEnB) begin
        wakeEnB <= wd & `WMI_WAKE_B_MASK;
      end
      if (wrWakeEnP) begin
        wakeEnPins <= wd;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      srcEnA <= `WMI_ZERO8;
      srcEnB <= `WMI_ZERO8;
    end else begin
      if (wrSrcEnA) begin
        srcEnA <= wd;
      end
      if (wrSrcEnB) begin
        srcEnB <= wd & `WMI_SRC_EN_B_MASK;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      masterEn <= 1'b0;
      wakeGate <= 1'b0;
    end else begin
      if (wrMasterEn) begin
        masterEn <= wd[`WMI_BIT0];
      end
      if (wrWakeGate) begin
        wakeGate <= wd[`WMI_BIT0];
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    rdData = `WMI_ZERO8;
    if (inRange) begin
      case (idx)
        `WMI_IDX_WAKE_STS_A: rdData = wakeStsA;
        `WMI_IDX_WAKE_STS_B: rdData = wakeStsBView;
        `WMI_IDX_WAKE_STS_P: rdData = wakeStsPins;
        `WMI_IDX_WAKE_EN_A:  rdData = wakeEnA;
        `WMI_IDX_WAKE_EN_B:  rdData = wakeEnB;
        `WMI_IDX_WAKE_EN_P:  rdData = wakeEnPins;
        `WMI_IDX_SUMMARY:    rdData = {7'h00, sumFlag};
        `WMI_IDX_MASTER_EN:  rdData = {7'h00, masterEn};
        `WMI_IDX_SRC_STS_A:  rdData = srcStsA;
        `WMI_IDX_SRC_STS_B:  rdData = srcStsB;
        `WMI_IDX_SRC_EN_A:   rdData = srcEnA;
        `WMI_IDX_SRC_EN_B:   rdData = srcEnB;
        `WMI_IDX_WAKE_GATE:  rdData = {7'h00, wakeGate};
        default:             rdData = `WMI_ZERO8;
      endcase
    end
  end

  // ----------------------------------------
  // wishbone answer
  // ----------------------------------------
  // one wait state; unmapped addresses answer with zero data
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wbAckO <= 1'b0;
      wbDatO <= `WMI_ZERO32;
    end else begin
      wbAckO <= wbReq & ~wbAckO;
      if (wbReq & ~wbAckO & ~wbWeI) begin
        wbDatO <= {24'h000000, rdData};
      end else begin
        wbDatO <= `WMI_ZERO32;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // pins follow the flags one clock later so every output is a flop
  wire next_mgmtIntOutN   = ~(mgmtActive & srcEnB[`WMI_ROUTE_PIN]);
  wire next_serialIrqMgmt = mgmtActive & srcEnB[`WMI_ROUTE_SIRQ];
  wire next_wakeOutN      = ~(wakeSummary & wakeGate);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mgmtIntOutN   <= 1'b1;
      serialIrqMgmt <= 1'b0;
      wakeOutN      <= 1'b1;
    end else begin
      mgmtIntOutN   <= next_mgmtIntOutN;
      serialIrqMgmt <= next_serialIrqMgmt;
      wakeOutN      <= next_wakeOutN;
    end
  end

endmodule

// *** wmi_irq_monitor.sv ***
// checker for the register bus and the interrupt outputs
`timescale 1ns/1ps
module wmi_irq_monitor (
  input logic        clk,
  input logic        nrst,
  input logic [7:0]  wbAdrI,
  input logic [31:0] wbDatI,
  input logic [3:0]  wbSelI,
  input logic        wbWeI,
  input logic        wbCycI,
  input logic        wbStbI,
  input logic [31:0] wbDatO,
  input logic        wbAckO,
  input logic        mgmtIntOutN,
  input logic        serialIrqMgmt,
  input logic        wakeOutN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_take;
    wbCycI && wbStbI && !wbAckO;
  endsequence
  sequence s_master_off;
    wbAckO && wbWeI && wbSelI[0] && wbAdrI == 8'h44 && !wbDatI[0];
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_ack_next; s_take |=> wbAckO; endproperty
  property p_ack_pulse; wbAckO |=> !wbAckO; endproperty
  property p_ack_cause; wbAckO |-> $past(wbCycI && wbStbI); endproperty
  property p_dat_idle; !wbAckO |-> wbDatO == 32'h0000_0000; endproperty
  property p_dat_upper; wbAckO |-> wbDatO[31:8] == 24'h00_0000; endproperty
  property p_unmapped; s_take ##0 (!wbWeI && wbAdrI[7]) |=> wbDatO == 32'h0000_0000; endproperty
  // pins follow the master enable one edge after the write lands and are checked at the second sample
  property p_master_off; s_master_off |-> ##2 (mgmtIntOutN && !serialIrqMgmt); endproperty
  property p_reset_idle; $rose(nrst) |-> mgmtIntOutN && !serialIrqMgmt && wakeOutN; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack one cycle after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  a_dat_upper: assert property (p_dat_upper) else $error("upper read data not zero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_master_off: assert property (p_master_off) else $error("interrupt while disabled");
  a_reset_idle: assert property (p_reset_idle) else $error("outputs busy after reset");
endmodule

// *** wmi_host_model.sv ***
// host chipset side: counts interrupt and wake arrivals
`timescale 1ns/1ps
module wmi_host_model (
  input  logic clk,
  input  logic nrst,
  input  logic mgmtIntOutN,
  input  logic wakeOutN,
  output int   mgmtSeen,
  output int   wakeSeen
);
  logic lastMgmt;
  logic lastWake;
  // the chipset reacts to the falling edge only, a held level is one event
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mgmtSeen <= 0;
      wakeSeen <= 0;
      lastMgmt <= 1'b1;
      lastWake <= 1'b1;
    end else begin
      lastMgmt <= mgmtIntOutN;
      lastWake <= wakeOutN;
      if (lastMgmt && !mgmtIntOutN) mgmtSeen <= mgmtSeen + 1;
      if (lastWake && !wakeOutN) wakeSeen <= wakeSeen + 1;
    end
  end
endmodule

// *** wmi_testbench.sv ***
// self-checking bench for the wake and management interrupt aggregator
`timescale 1ns/1ps
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin errorCnt++; \
  $display("[ERR] %0t got %h expected %h", $time, a, b); end end
bind wmi_wake_mgmt_irq wmi_irq_monitor i_wmi_irq_monitor (.clk(clk), .nrst(nrst),
  .wbAdrI(wbAdrI), .wbDatI(wbDatI), .wbSelI(wbSelI), .wbWeI(wbWeI), .wbCycI(wbCycI),
  .wbStbI(wbStbI), .wbDatO(wbDatO), .wbAckO(wbAckO), .mgmtIntOutN(mgmtIntOutN),
  .serialIrqMgmt(serialIrqMgmt), .wakeOutN(wakeOutN));
module testbench;
  logic        clk = 0, nrst = 0, wbWeI = 0, wbCycI = 0, wbStbI = 0, wdt = 0, intr = 0;
  logic [7:0]  wbAdrI = 8'h00, pinEvt = 8'h00, fwSts = 8'h00, fwEn = 8'h00, expV;
  logic [31:0] wbDatI = 32'h0000_0000;
  logic [3:0]  wbSelI = 4'h0;
  logic [5:1]  wakeA = 5'h00;
  logic        mainN = 1, porIn = 1, lowIn = 0, ppAct = 0, ppAck = 0, serB = 0, serA = 0;
  logic        flop = 0, keyboard_wake = 0, mouse = 0;
  logic [15:0] mbSrc = 16'h0000, mbEn = 16'h0000, rnd = 16'h4A11;
  wire  [31:0] wbDatO;
  wire         wbAckO, mgmtIntOutN, serialIrqMgmt, wakeOutN;
  int          errorCnt = 0, totalChecks = 0, mgmtSeen, wakeSeen, i;
  logic [7:0]  expQ[$];
  logic [5:0]  idxT[4] = '{6'h05, 6'h06, 6'h07, 6'h11};
  logic [7:0]  rwT[4] = '{8'h3E, 8'h7F, 8'hFF, 8'h01};
  always #10 clk = ~clk;
  wmi_wake_mgmt_irq i_wmi_wake_mgmt_irq (.clk(clk), .nrst(nrst), .wbAdrI(wbAdrI),
    .wbDatI(wbDatI), .wbSelI(wbSelI), .wbWeI(wbWeI), .wbCycI(wbCycI), .wbStbI(wbStbI),
    .wbDatO(wbDatO), .wbAckO(wbAckO), .wakeEvtA(wakeA), .pinWakeEvt(pinEvt),
    .watchdogEvt(wdt), .intrusionIn(intr), .mainRstN(mainN), .vbatPorIn(porIn),
    .vbatLowIn(lowIn), .parportActive(ppAct), .parportAck(ppAck), .serialBIrq(serB),
    .serialAIrq(serA), .floppyIrq(flop), .mbxSrc(mbSrc), .mbxEn(mbEn), .fwEvtSts(fwSts),
    .fwEvtEn(fwEn), .keyboardIrq(keyboard_wake), .mouseIrq(mouse), .mgmtIntOutN(mgmtIntOutN),
    .serialIrqMgmt(serialIrqMgmt), .wakeOutN(wakeOutN));
  wmi_host_model i_wmi_host_model (.clk(clk), .nrst(nrst), .mgmtIntOutN(mgmtIntOutN),
    .wakeOutN(wakeOutN), .mgmtSeen(mgmtSeen), .wakeSeen(wakeSeen));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // ----------------------------------------
  // bus master: hold the request until ack is sampled
  // ----------------------------------------
  task automatic bus(input logic [5:0] idx, input logic w, input logic [7:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    rnd = lfsr(rnd);
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbAdrI <= {idx, 2'b00};
    wbWeI <= w;
    wbSelI <= s;
    wbDatI <= {rnd, rnd[7:0], d};
    do begin
      @(posedge clk);
    end while (wbAckO !== 1'b1);
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d, 4'h1);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    expQ.push_back(e);
    bus(idx, 1'b0, 8'h00, 4'hF);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // the oldest note is matched against each read answer
  always @(posedge clk) begin
    if (wbAckO === 1'b1 && !wbWeI && expQ.size() > 0) begin
      expV = expQ.pop_front();
      `CHK(wbDatO[7:0], expV)
    end
  end
  task automatic reportAndStop;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    $display("[ERR] %0t timeout", $time);
    reportAndStop;
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 4; i++) rd(idxT[i], 8'h00);
    rd(6'h10, 8'h00);
    rd(6'h12, 8'h03);
    $display("reset values done");
    for (i = 0; i < 4; i++) begin
      wr(idxT[i], 8'hFF);
      rd(idxT[i], rwT[i]);
      bus(idxT[i], 1'b1, 8'h00, 4'hE);
      rd(idxT[i], rwT[i]);
      wr(idxT[i], 8'h00);
    end
    wr(6'h20, 8'hFF);
    rd(6'h20, 8'h00);
    wr(6'h12, 8'hFF);
    rd(6'h12, 8'h02);
    @(posedge clk);
    lowIn <= 1'b1;
    mainN <= 1'b0;
    repeat (2) @(posedge clk);
    mainN <= 1'b1;
    settle(3);
    rd(6'h12, 8'h03);
    wr(6'h12, 8'h01);
    lowIn <= 1'b0;
    ppAct <= 1'b1;
    settle(3);
    rd(6'h12, 8'h00);
    for (i = 1; i < 8; i++) begin
      rnd = lfsr(rnd);
      case (i)
        1: ppAck <= 1'b1;
        2: serB <= 1'b1;
        3: serA <= 1'b1;
        4: flop <= 1'b1;
        5: mbSrc <= {rnd[15:1], 1'b1};
        6: begin
          mbSrc <= {rnd[15:9], 1'b1, rnd[7:1], 1'b0};
          mbEn <= 16'h0100;
        end
        default: begin
          fwSts <= rnd[7:0] | 8'h10;
          fwEn <= 8'h10;
        end
      endcase
      settle(3);
      rd(6'h12, 8'h01 << i);
      {ppAck, serB, serA, flop, mbSrc, fwSts} <= '0;
      @(posedge clk);
    end
    $display("source flags done");
    wr(6'h15, 8'h08);
    wr(6'h16, 8'hE0);
    wr(6'h11, 8'h01);
    serA <= 1'b1;
    settle(3);
    `CHK(mgmtIntOutN, 1'b0)
    `CHK(serialIrqMgmt, 1'b1)
    rd(6'h10, 8'h01);
    wr(6'h03, 8'hFF);
    rd(6'h03, 8'h01);
    wr(6'h10, 8'h00);
    rd(6'h10, 8'h01);
    wr(6'h10, 8'h01);
    rd(6'h10, 8'h01);
    serA <= 1'b0;
    wr(6'h10, 8'h01);
    rd(6'h10, 8'h00);
    keyboard_wake <= 1'b1;
    wr(6'h16, 8'h42);
    settle(3);
    `CHK({mgmtIntOutN, serialIrqMgmt}, 2'b11)
    wr(6'h11, 8'h00);
    settle(2);
    `CHK(serialIrqMgmt, 1'b0)
    `CHK(mgmtSeen, 1)
    @(posedge clk);
    keyboard_wake <= 1'b0;
    wdt <= 1'b1;
    intr <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    rd(6'h13, 8'h0C);
    wr(6'h13, 8'h08);
    rd(6'h13, 8'h04);
    wr(6'h03, 8'hFF);
    rd(6'h03, 8'h40);
    intr <= 1'b0;
    $display("interrupt path done");
    wr(6'h07, 8'h80);
    pinEvt <= 8'h80;
    wakeA <= 5'h15;
    @(posedge clk);
    pinEvt <= 8'h00;
    wakeA <= 5'h00;
    rd(6'h04, 8'h80);
    rd(6'h02, 8'h2A);
    settle(2);
    `CHK(wakeOutN, 1'b1)
    wr(6'h18, 8'h01);
    settle(3);
    `CHK(wakeOutN, 1'b0)
    `CHK(wakeSeen, 1)
    $display("wake path done");
    reportAndStop;
  end
endmodule
